// ### branch_trace_defines.svh
// Purpose: offsets, field positions, reset values and counts for the
//          branch trace and precise sampling block
// Assumes: 64-bit register port, byte addresses
// Notes:   definitions only
`ifndef BRANCH_TRACE_DEFINES_SVH
`define BRANCH_TRACE_DEFINES_SVH

// register offsets
`define OFS_FILTER 9'h000
`define OFS_EVSEL 9'h008
`define OFS_COUNT 9'h010
`define OFS_CTRL 9'h018
`define OFS_REC_IP 9'h020
`define OFS_REC_GPR0 9'h028
`define OFS_REC_GPR1 9'h030
`define OFS_REC_GPR2 9'h038
`define OFS_REC_GPR3 9'h040
// buffer window: addr[8] set, addr[7:4] entry, addr[3] selects target
`define BUF_WIN_BIT 8
`define BUF_TGT_BIT 3

// filter bits: a set bit suppresses its class
`define FLT_RING0 0
`define FLT_RING3 1
`define FLT_TYPE_BASE 2
`define FLT_WIDTH 9
`define FILTER_RESET 9'h000

// event select fields
`define EV_KIND_LO 0
`define EV_MISP_BIT 4
`define EV_EN_BIT 5
`define EV_INV_BIT 6
`define EV_CMASK_LO 8
`define EVSEL_RESET 16'h0000

// control write bits
`define CTRL_UNFREEZE 0
`define CTRL_CLR_REC 1

// status fields
`define ST_FROZEN 0
`define ST_SHADOW 1
`define ST_ARMED 2
`define ST_RECV 3
`define ST_PEND 4
`define ST_TOS_LO 8

// cycles between counter overflow and arming
`define SHADOW_CYCLES 4'd10

`endif

// ### branch_trace_pkg.sv
// Purpose: types for the branch trace and precise sampling block
// Assumes: nothing
// Notes:   constants live in branch_trace_defines.svh
package branch_trace_pkg;

  // retired branch class, index into filter bits above the ring bits
  typedef enum logic [2:0] {
    br_cond,
    br_near_rel_call,
    br_near_ind_call,
    br_near_ret,
    br_near_ind_jmp,
    br_near_rel_jmp,
    br_far
  } br_class_type;

  // selectable precise events
  typedef enum logic [3:0] {
    ev_all_branches,
    ev_near_call,
    ev_cond_branch,
    ev_inst_retired,
    ev_uops_retired,
    ev_sse_class,
    ev_x87_assist
  } event_kind_type;

  // sampling sequence
  typedef enum logic [1:0] {
    smp_idle,
    smp_shadow,
    smp_armed
  } sample_state_type;

endpackage

// ### branch_trace_buffer.sv
// Purpose: 16-entry rotating store of taken branch source/target pairs
// Assumes: write and freeze decided by the caller
// Notes:   read port is combinational, caller registers it
`timescale 1ns/1ns

module branch_trace_buffer
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // write side
  input wire logic wr_en,
  input wire logic [47:0] wr_src,
  input wire logic [47:0] wr_tgt,
  // read side
  input wire logic [3:0] rd_idx,
  output logic [47:0] rd_src,
  output logic [47:0] rd_tgt,
  // newest entry
  output logic [3:0] tos
);

  logic [47:0] src_mem [16]; // source addresses
  logic [47:0] tgt_mem [16]; // target addresses
  logic [3:0] tos_q; // newest entry
  logic [3:0] tos_d; // slot to write next

  // next slot wraps at 16, so the oldest entry is overwritten
  assign tos_d = tos_q + 4'h1;

  // top-of-buffer pointer, starts so the first write lands in entry 0
  always_ff @(posedge mclk)
  begin
    if (rst)
      tos_q <= 4'hf;
    else if (wr_en)
      tos_q <= tos_d;
  end

  // entry storage, one pair per taken branch
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      src_mem[tos_d] <= wr_src;
      tgt_mem[tos_d] <= wr_tgt;
    end
  end

  // read port
  assign rd_src = src_mem[rd_idx];
  assign rd_tgt = tgt_mem[rd_idx];
  assign tos = tos_q;

endmodule

// ### branch_trace_sampler.sv
// Purpose: branch trace recording and precise sampling of retired events
// Assumes: retirement inputs come from logic on mclk, one slot per cycle
// Notes:   registers reached over a plain 64-bit address/strobe port
//
// What this block does
// - record source and target of filtered taken branches
// - sixteen pairs, newest overwrites the oldest
// - filter select register filters type and ring
// - ring 0, ring 3 or both; both default
// - all filter bits clear records everything
// - set bit suppresses its class
// - branch, call, conditional events; retired or mispredicted
// - branch sample holds the branch target
// - taken sample ip equals newest target if the filter passes that branch and the buffer is not frozen
// - events in the shadow after overflow ignored
// - armed sampling records next qualifying event
// - overflow freezes the buffer after a delay
// - masked interrupts delay the interrupt, not capture
// - high cmask with invert counts every cycle
// - instruction, micro-op, sse and assist events
// - assist event sees x87 assists only
// - sample record keeps general register values
// - counter overflow arms sampling
`timescale 1ns/1ns
`include "branch_trace_defines.svh"

module branch_trace_sampler
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // retirement slot
  input wire logic ret_valid,
  input wire logic ret_is_branch,
  input wire logic ret_taken,
  input wire logic ret_mispred,
  input wire logic ret_ring3,
  input wire logic [2:0] ret_class,
  input wire logic [47:0] ret_ip,
  input wire logic [47:0] ret_tgt,
  input wire logic [2:0] ret_inst_count,
  input wire logic [3:0] ret_uop_count,
  input wire logic ret_sse_class,
  input wire logic ret_x87_assist,
  input wire logic [255:0] ret_gpr,
  input wire logic intr_masked,
  // register port
  input wire logic [8:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [63:0] reg_rdata,
  // sampling interrupt
  output logic perf_monitor_interrupt
);

  logic [8:0] filter_q; // branch_filter_select
  logic [15:0] evsel_q; // event select
  logic [47:0] count_q; // event counter
  branch_trace_pkg::sample_state_type state_q; // sampling sequence
  logic [3:0] shadow_q; // shadow cycles left
  logic frozen_q; // buffer frozen
  logic recv_q; // record holds a sample
  logic pend_q; // interrupt owed
  logic irq_q; // interrupt pulse
  logic [47:0] rec_ip_q; // record instruction_pointer
  logic [255:0] rec_gpr_q; // record general registers
  logic [63:0] rdata_q; // read answer

  logic [8:0] class_bit; // filter bit of this branch class
  logic ring_ok; // ring not suppressed
  logic type_ok; // class not suppressed
  logic buf_wr; // write into buffer
  logic [3:0] tos; // newest entry
  logic [47:0] buf_src; // read source
  logic [47:0] buf_tgt; // read target
  logic [3:0] ev_inc; // raw event amount this cycle
  logic [7:0] cmask; // threshold
  logic ev_hit; // event condition true
  logic [3:0] step; // counter increment
  logic [48:0] count_sum; // counter plus carry
  logic overflow; // counter wrapped
  logic is_call; // near call class
  logic branch_kind; // selected event is a branch event
  logic wr_filter; // filter write
  logic wr_evsel; // event select write
  logic wr_count; // counter write
  logic wr_ctrl; // control write
  logic [63:0] status; // status word
  logic [63:0] rd_mux; // read selection

  // address decode of writes
  assign wr_filter = reg_wr && (reg_addr == `OFS_FILTER);
  assign wr_evsel = reg_wr && (reg_addr == `OFS_EVSEL);
  assign wr_count = reg_wr && (reg_addr == `OFS_COUNT);
  assign wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);

  // filter bit of the retiring class, one-hot above the ring bits
  assign class_bit = 9'h001 << (`FLT_TYPE_BASE + ret_class);

  // ring filter: clear bit captures that ring, both clear is default
  assign ring_ok = ret_ring3 ? !filter_q[`FLT_RING3]
                             : !filter_q[`FLT_RING0];

  // a set bit suppresses its class; all clear lets every class in
  assign type_ok = ((filter_q & class_bit) == 9'h000);

  // only taken branches, never while frozen
  assign buf_wr = ret_valid && ret_is_branch && ret_taken && ring_ok
                  && type_ok && !frozen_q;

  // rotating buffer of source/target pairs
  branch_trace_buffer u_buf
  (
    .mclk(mclk),
    .rst(rst),
    .wr_en(buf_wr),
    .wr_src(ret_ip),
    .wr_tgt(ret_tgt),
    .rd_idx(reg_addr[7:4]),
    .rd_src(buf_src),
    .rd_tgt(buf_tgt),
    .tos(tos)
  );

  // near call classes
  assign is_call = (ret_class == 3'(branch_trace_pkg::br_near_rel_call))
                || (ret_class == 3'(branch_trace_pkg::br_near_ind_call));

  // raw event amount for the selected kind
  always_comb
  begin
    ev_inc = 4'h0;
    branch_kind = 1'b0;
    case (evsel_q[`EV_KIND_LO +: 4])
      branch_trace_pkg::ev_all_branches:
      begin
        branch_kind = 1'b1;
        ev_inc = {3'h0, ret_valid && ret_is_branch};
      end
      branch_trace_pkg::ev_near_call:
      begin
        branch_kind = 1'b1;
        ev_inc = {3'h0, ret_valid && ret_is_branch && is_call};
      end
      branch_trace_pkg::ev_cond_branch:
      begin
        branch_kind = 1'b1;
        ev_inc = {3'h0, ret_valid && ret_is_branch
                  && (ret_class == 3'(branch_trace_pkg::br_cond))};
      end
      branch_trace_pkg::ev_inst_retired:
        ev_inc = ret_valid ? {1'b0, ret_inst_count} : 4'h0;
      branch_trace_pkg::ev_uops_retired:
        ev_inc = ret_valid ? ret_uop_count : 4'h0;
      branch_trace_pkg::ev_sse_class:
        ev_inc = {3'h0, ret_valid && ret_sse_class};
      branch_trace_pkg::ev_x87_assist:
        // sse assists have no input here, only x87 ones count
        ev_inc = {3'h0, ret_valid && ret_x87_assist};
      default:
        ev_inc = 4'h0;
    endcase
    // mispredicted-only variant of the branch events
    if (branch_kind && evsel_q[`EV_MISP_BIT] && !ret_mispred)
      ev_inc = 4'h0;
  end

  // threshold compare; high cmask inverted is true in every cycle,
  // halted or not, since ev_inc is at most 15 and stays below any cmask above 15
  assign cmask = evsel_q[`EV_CMASK_LO +: 8];
  always_comb
  begin
    if (cmask == 8'h00)
      ev_hit = (ev_inc != 4'h0);
    else if (evsel_q[`EV_INV_BIT])
      ev_hit = ({4'h0, ev_inc} < cmask);
    else
      ev_hit = ({4'h0, ev_inc} >= cmask);
  end

  // with a threshold the counter counts cycles, else event amounts
  assign step = (cmask == 8'h00) ? ev_inc : {3'h0, ev_hit};
  assign count_sum = {1'b0, count_q} + {45'h0, step};
  assign overflow = evsel_q[`EV_EN_BIT] && count_sum[48];

  // filter select register
  always_ff @(posedge mclk)
  begin
    if (rst)
      filter_q <= `FILTER_RESET;
    else if (wr_filter)
      filter_q <= reg_wdata[`FLT_WIDTH-1:0];
  end

  // event select register
  always_ff @(posedge mclk)
  begin
    if (rst)
      evsel_q <= `EVSEL_RESET;
    else if (wr_evsel)
      evsel_q <= reg_wdata[15:0];
  end

  // event counter, software preset wins over counting
  always_ff @(posedge mclk)
  begin
    if (rst)
      count_q <= 48'h0;
    else if (wr_count)
      count_q <= reg_wdata[47:0];
    else if (evsel_q[`EV_EN_BIT])
      count_q <= count_sum[47:0];
  end

  // sampling sequence: overflow, shadow, armed, capture
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= branch_trace_pkg::smp_idle;
      shadow_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        branch_trace_pkg::smp_idle:
          if (overflow)
          begin
            state_q <= branch_trace_pkg::smp_shadow;
            shadow_q <= `SHADOW_CYCLES - 4'd1;
          end
        branch_trace_pkg::smp_shadow:
          // events here are not seen by the sampler
          if (shadow_q == 4'h0)
            state_q <= branch_trace_pkg::smp_armed;
          else
            shadow_q <= shadow_q - 4'd1;
        branch_trace_pkg::smp_armed:
          if (ev_hit)
            state_q <= branch_trace_pkg::smp_idle;
        default:
          state_q <= branch_trace_pkg::smp_idle;
      endcase
    end
  end

  // precise sample record, written on the first hit once armed
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rec_ip_q <= 48'h0;
      rec_gpr_q <= 256'h0;
    end
    else if (state_q == branch_trace_pkg::smp_armed && ev_hit)
    begin
      // branch events keep the target, the same value the buffer
      // takes as its newest target in this cycle when buf_wr is set
      rec_ip_q <= branch_kind ? ret_tgt : ret_ip;
      rec_gpr_q <= ret_gpr;
    end
  end

  // record valid flag; capture wins over a software clear
  always_ff @(posedge mclk)
  begin
    if (rst)
      recv_q <= 1'b0;
    else if (state_q == branch_trace_pkg::smp_armed && ev_hit)
      recv_q <= 1'b1;
    else if (wr_ctrl && reg_wdata[`CTRL_CLR_REC])
      recv_q <= 1'b0;
  end

  // freeze once the sample is taken, the delay after overflow being
  // the shadow; the sampled branch itself still enters the buffer when buf_wr is set
  always_ff @(posedge mclk)
  begin
    if (rst)
      frozen_q <= 1'b0;
    else if (state_q == branch_trace_pkg::smp_armed && ev_hit)
      frozen_q <= 1'b1;
    else if (wr_ctrl && reg_wdata[`CTRL_UNFREEZE])
      frozen_q <= 1'b0;
  end

  // interrupt owed after a capture, held while interrupts are masked
  always_ff @(posedge mclk)
  begin
    if (rst)
      pend_q <= 1'b0;
    else if (state_q == branch_trace_pkg::smp_armed && ev_hit)
      pend_q <= 1'b1;
    else if (!intr_masked)
      pend_q <= 1'b0;
  end

  // one-cycle interrupt pulse once unmasked
  always_ff @(posedge mclk)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= pend_q && !intr_masked;
  end

  // status word
  always_comb
  begin
    status = 64'h0;
    status[`ST_FROZEN] = frozen_q;
    status[`ST_SHADOW] = (state_q == branch_trace_pkg::smp_shadow);
    status[`ST_ARMED] = (state_q == branch_trace_pkg::smp_armed);
    status[`ST_RECV] = recv_q;
    status[`ST_PEND] = pend_q;
    status[`ST_TOS_LO +: 4] = tos;
  end

  // read selection, unmapped addresses read zero
  always_comb
  begin
    rd_mux = 64'h0;
    if (reg_addr[`BUF_WIN_BIT])
      rd_mux = {16'h0, reg_addr[`BUF_TGT_BIT] ? buf_tgt : buf_src};
    else
    begin
      case (reg_addr)
        `OFS_FILTER: rd_mux = {55'h0, filter_q};
        `OFS_EVSEL: rd_mux = {48'h0, evsel_q};
        `OFS_COUNT: rd_mux = {16'h0, count_q};
        `OFS_CTRL: rd_mux = status;
        `OFS_REC_IP: rd_mux = {16'h0, rec_ip_q};
        `OFS_REC_GPR0: rd_mux = rec_gpr_q[63:0];
        `OFS_REC_GPR1: rd_mux = rec_gpr_q[127:64];
        `OFS_REC_GPR2: rd_mux = rec_gpr_q[191:128];
        `OFS_REC_GPR3: rd_mux = rec_gpr_q[255:192];
        default: rd_mux = 64'h0;
      endcase
    end
  end

  // read data stands for the one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_q <= 64'h0;
    else if (reg_rd)
      rdata_q <= rd_mux;
    else
      rdata_q <= 64'h0;
  end

  assign reg_rdata = rdata_q;
  assign perf_monitor_interrupt = irq_q;

endmodule

// ### bt_sva.sv
// Purpose: port checks for branch_trace_sampler
// Assumes: register and interrupt timing as handed over
// Notes:   bound to the sampler at the foot of this file
`timescale 1ns/1ns
`include "branch_trace_defines.svh"

module bt_sva
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // inputs watched
  input wire logic intr_masked,
  input wire logic [8:0] reg_addr,
  input wire logic reg_rd,
  // outputs watched
  input wire logic [63:0] reg_rdata,
  input wire logic perf_monitor_interrupt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // read data stands only after a read strobe
  rd_idle_a:
    assert property (!reg_rd |=> reg_rdata == 64'h0)
    else $error("read data without a read");
  // holes above the record registers read zero
  unmapped_zero_a:
    assert property (reg_rd && !reg_addr[8] && reg_addr > 9'h040
      |=> reg_rdata == 64'h0)
    else $error("unmapped read not zero");
  // status has only its defined fields
  status_fields_a:
    assert property (reg_rd && reg_addr == `OFS_CTRL
      |=> reg_rdata[63:12] == 52'h0 && reg_rdata[7:5] == 3'h0)
    else $error("status spare bits set");
  // buffer entries are 48-bit addresses
  buf_width_a:
    assert property (reg_rd && reg_addr[8] |=> reg_rdata[63:48] == 16'h0)
    else $error("buffer entry too wide");
  // sample address is 48 bits
  rec_width_a:
    assert property (reg_rd && reg_addr == `OFS_REC_IP
      |=> reg_rdata[63:48] == 16'h0)
    else $error("sample address too wide");
  // interrupt is a single pulse
  intr_pulse_a:
    assert property (perf_monitor_interrupt |=> !perf_monitor_interrupt)
    else $error("interrupt longer than a cycle");
  // no interrupt while interrupts are masked
  intr_masked_a:
    assert property (perf_monitor_interrupt |-> !$past(intr_masked))
    else $error("interrupt while masked");
  // a new sample needs a new overflow and shadow
  intr_spacing_a:
    assert property (perf_monitor_interrupt
      |=> !perf_monitor_interrupt [*8])
    else $error("interrupts too close");
endmodule

bind branch_trace_sampler bt_sva chk
(
  .mclk(mclk),
  .rst(rst),
  .intr_masked(intr_masked),
  .reg_addr(reg_addr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .perf_monitor_interrupt(perf_monitor_interrupt)
);

// ### core_model.sv
// Purpose: retirement pipeline stand-in feeding the sampler
// Assumes: one slot per cycle, queued by the bench
// Notes:   idle slots turn the payload over so stale data never holds for two cycles running
`timescale 1ns/1ns

module core_model
(
  // clock
  input wire logic mclk,
  // retirement slot
  output logic ret_valid,
  output logic ret_is_branch,
  output logic ret_taken,
  output logic ret_mispred,
  output logic ret_ring3,
  output logic [2:0] ret_class,
  output logic [47:0] ret_ip,
  output logic [47:0] ret_tgt,
  output logic [2:0] ret_inst_count,
  output logic [3:0] ret_uop_count,
  output logic ret_sse_class,
  output logic ret_x87_assist,
  output logic [255:0] ret_gpr
);
  // one queued retirement
  typedef struct {logic b; logic k; logic r; logic [2:0] c;
    logic [47:0] ip; logic [47:0] tg; logic [255:0] g;} slot_type;
  slot_type q[$]; // slots waiting
  slot_type s; // slot now driven
  // queue a retirement
  task automatic put(input logic b, input logic k, input logic r,
    input logic [2:0] c, input logic [47:0] ip, input logic [47:0] tg,
    input logic [255:0] g);
    q.push_back('{b, k, r, c, ip, tg, g});
  endtask
  initial
  begin
    ret_valid = 1'b0;
    {ret_is_branch, ret_taken, ret_mispred, ret_ring3} = 4'h0;
    {ret_sse_class, ret_x87_assist, ret_class} = 5'h00;
    {ret_ip, ret_tgt, ret_gpr} = '0;
    ret_inst_count = 3'h1;
    ret_uop_count = 4'h2;
  end
  // one slot per edge
  always @(posedge mclk)
  begin
    if (q.size() != 0)
    begin
      s = q.pop_front();
      ret_valid <= 1'b1;
      ret_is_branch <= s.b;
      ret_taken <= s.k;
      // mispredicted when the source is odd, so it follows the payload
      ret_mispred <= s.ip[0];
      ret_ring3 <= s.r;
      ret_class <= s.c;
      ret_ip <= s.ip;
      ret_tgt <= s.tg;
      ret_gpr <= s.g;
    end
    else
    begin
      // nothing retires: payload scrambled
      ret_valid <= 1'b0;
      ret_ip <= ~ret_ip;
      ret_tgt <= ~ret_tgt;
      ret_gpr <= ~ret_gpr;
    end
  end
endmodule

// ### tb.sv
// Purpose: self-checking bench for branch_trace_sampler
// Assumes: core_model feeds retirements, bench drives registers
// Notes:   a bench copy of the trace buffer gives the expectations
`timescale 1ns/1ns
`include "branch_trace_defines.svh"

module tb;
  // clock, reset, register port
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] reg_addr = 9'h000;
  logic [63:0] reg_wdata = 64'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic intr_masked = 1'b0;
  logic [63:0] reg_rdata;
  logic perf_monitor_interrupt;
  // retirement slot
  logic ret_valid, ret_is_branch, ret_taken, ret_mispred, ret_ring3;
  logic ret_sse_class, ret_x87_assist;
  logic [2:0] ret_class, ret_inst_count;
  logic [3:0] ret_uop_count;
  logic [47:0] ret_ip, ret_tgt;
  logic [255:0] ret_gpr;
  // counters and expected results
  int num_errors = 0;
  int cmp_count = 0;
  int irq_n = 0; // interrupts expected
  logic [63:0] rd_q[$]; // expected read data
  logic [63:0] mk_q[$]; // bits compared
  logic rd_d = 1'b0; // read taken last edge
  // bench copy of the buffer
  logic [47:0] b_src[16];
  logic [47:0] b_tgt[16];
  logic [3:0] b_tos = 4'hf;
  logic [47:0] a, t;
  logic [255:0] g;
  logic fz = 1'b0; // buffer frozen
  logic [8:0] fl[5] = '{9'h135, 9'h001, 9'h002, 9'h17c, 9'h000};
  always #4 mclk = ~mclk;

  branch_trace_sampler DUT
  (
    .mclk(mclk), .rst(rst), .ret_valid(ret_valid),
    .ret_is_branch(ret_is_branch), .ret_taken(ret_taken),
    .ret_mispred(ret_mispred), .ret_ring3(ret_ring3),
    .ret_class(ret_class), .ret_ip(ret_ip), .ret_tgt(ret_tgt),
    .ret_inst_count(ret_inst_count), .ret_uop_count(ret_uop_count),
    .ret_sse_class(ret_sse_class), .ret_x87_assist(ret_x87_assist),
    .ret_gpr(ret_gpr), .intr_masked(intr_masked), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .perf_monitor_interrupt(perf_monitor_interrupt)
  );
  core_model core
  (
    .mclk(mclk), .ret_valid(ret_valid), .ret_is_branch(ret_is_branch),
    .ret_taken(ret_taken), .ret_mispred(ret_mispred),
    .ret_ring3(ret_ring3), .ret_class(ret_class), .ret_ip(ret_ip),
    .ret_tgt(ret_tgt), .ret_inst_count(ret_inst_count),
    .ret_uop_count(ret_uop_count), .ret_sse_class(ret_sse_class),
    .ret_x87_assist(ret_x87_assist), .ret_gpr(ret_gpr)
  );

  // compare one result
  task automatic chk(input string nm, input logic [63:0] e,
    input logic [63:0] s);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // verdict and end of run
  task automatic results();
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // register write, one cycle
  task automatic wr(input logic [8:0] ad, input logic [63:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // register read, expectation noted first
  task automatic rd(input logic [8:0] ad, input logic [63:0] e,
    input logic [63:0] m = '1);
    rd_q.push_back(e & m);
    mk_q.push_back(m);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  // queue a taken branch, track where it should land
  task automatic br(input logic r3, input logic [2:0] c,
    input logic [8:0] f);
    a = 48'({$urandom(), $urandom()});
    t = 48'({$urandom(), $urandom()});
    for (int j = 0; j < 8; j++)
      g[32*j +: 32] = $urandom();
    core.put(1'b1, 1'b1, r3, c, a, t, g);
    if (!f[r3] && !f[2 + c] && !fz)
    begin
      b_tos = b_tos + 4'h1;
      b_src[b_tos] = a;
      b_tgt[b_tos] = t;
    end
  endtask
  // let queued slots retire
  task automatic drain();
    while (core.q.size() != 0)
      @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  // read pointer and every entry back
  task automatic cbuf();
    drain();
    rd(`OFS_CTRL, {52'h0, b_tos, 8'h0}, 64'hf00);
    for (int i = 0; i < 16; i++)
    begin
      rd(9'h100 + 9'(16 * i), {16'h0, b_src[i]});
      rd(9'h108 + 9'(16 * i), {16'h0, b_tgt[i]});
    end
  endtask
  // overflow, ten shadow calls, a jump, then the sampled call
  task automatic smp(input logic m);
    wr(`OFS_EVSEL, 64'h21);
    wr(`OFS_COUNT, 64'hffff_ffff_ffff);
    intr_masked <= m;
    irq_n = irq_n + int'(!m);
    for (int i = 0; i < 11; i++)
      br(1'b1, 3'd1, 9'h0);
    br(1'b1, 3'd5, 9'h0);
    br(1'b1, 3'd1, 9'h0);
    drain();
    fz = 1'b1;
    rd(`OFS_REC_IP, {16'h0, t});
    rd(`OFS_REC_GPR0, g[63:0]);
    rd(`OFS_REC_GPR3, g[255:192]);
    rd(`OFS_CTRL, {59'h0, m, 4'h9}, 64'h1f);
    br(1'b0, 3'd5, 9'h0);
    cbuf();
    irq_n = irq_n + int'(m);
    intr_masked <= 1'b0;
    repeat (3) @(posedge mclk);
    wr(`OFS_CTRL, 64'h3);
    fz = 1'b0;
  endtask
  // event count over n taken conditional branches from a zero preset;
  // mispredicted-only counts the branches the model marked odd
  task automatic evc(input logic [15:0] ev, input int n,
    input logic [63:0] e);
    int k;
    k = 0;
    wr(`OFS_EVSEL, {48'h0, ev});
    wr(`OFS_COUNT, 64'h0);
    for (int i = 0; i < n; i++)
    begin
      br(1'b0, 3'd0, 9'h0);
      k = k + int'(a[0]);
    end
    drain();
    rd(`OFS_COUNT, ev[4] ? 64'(k) : e);
  endtask

  // results watcher: read data after a read, interrupt pulses
  always @(posedge mclk)
    rd_d <= reg_rd;
  always @(negedge mclk)
  begin
    if (rd_d)
      chk("reg_rdata", rd_q.pop_front(), reg_rdata & mk_q.pop_front());
    if (perf_monitor_interrupt === 1'b1)
    begin
      chk("perf_monitor_interrupt", 64'h1, 64'(irq_n > 0));
      irq_n = irq_n - 1;
    end
  end
  // hang guard, far beyond the roughly 800 cycles the tests need
  initial
  begin
    #200000;
    num_errors++;
    results();
  end
  // main sequence
  initial
  begin
    void'($urandom(86));
    fl[4] = 9'($urandom());
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(`OFS_CTRL, 64'hf00);
    rd(`OFS_FILTER, 64'h0);
    rd(`OFS_COUNT, 64'h0);
    rd(9'h048, 64'h0);
    for (int i = 0; i < 18; i++)
      br(i[0], 3'(i % 7), 9'h0);
    core.put(1'b1, 1'b0, 1'b0, 3'd0, a, t, g);
    cbuf();
    foreach (fl[k])
    begin
      wr(`OFS_FILTER, {55'h0, fl[k]});
      for (int r = 0; r < 2; r++)
        for (int c = 0; c < 7; c++)
          br(r[0], 3'(c), fl[k]);
      cbuf();
    end
    wr(`OFS_FILTER, 64'h0);
    smp(1'b0);
    smp(1'b1);
    evc(16'h0024, 5, 64'ha);
    evc(16'h0023, 5, 64'h5);
    evc(16'h0022, 5, 64'h5);
    evc(16'h0030, 5, 64'h0);
    evc(16'h0026, 5, 64'h0);
    evc(16'hff65, 0, 64'h3);
    chk("irq_left", 64'h0, 64'(irq_n));
    results();
  end
endmodule
